/* inc/pmb_pkg.sv */
// Function
// - command codes d0 to ef are the vendor command space
// - slave only: never starts a transfer, never toggles the clock
// - clock may be held low while busy, each hold at most 25 ms
// - clock held only after the ninth acknowledge bit of a received byte
// - bus held low over 35 ms: abandon transfer, release both lines
// - works at 100 kHz and 400 kHz alike, no rate setting
// - commands accepted with or without a trailing check byte
// - check byte is crc-8, poly x8+x2+x+1, over every message byte
// - alert idles high, latches low on change, relatches after clear
// - alert on supply faults, comm errors, check errors, bad commands
// - alert released by status byte/word read, clear, output recycle
// - unsupported command or bad data sets status bits and alert
// - read of an unsupported command returns all-zero bytes
// - standard write: command, up to two bytes low first, check, stop
// - standard read: command, restart, low, high, check, master nacks
// - block transfers carry a count and up to 48 bytes then check
// - linear values: 5-bit signed exponent over 11-bit signed mantissa
// - output voltage values: 16-bit mantissa, fixed exponent of -9
// - slave address is 1011 plus three strap bits
// - broadcast address 0 accepts writes, flags reads as invalid
// - command 03 clears status and alert, persistent faults reflag
package pmb_pkg;
   localparam logic [3:0] ADDR_HI = 4'hb;
   localparam logic [6:0] ADDR_BCAST = 7'h00;
   localparam logic [7:0] CMD_OPER = 8'h01;
   localparam logic [7:0] CMD_CLR = 8'h03;
   localparam logic [7:0] CMD_WPROT = 8'h10;
   localparam logic [7:0] CMD_VOUT = 8'h21;
   localparam logic [7:0] CMD_STB = 8'h78;
   localparam logic [7:0] CMD_STW = 8'h79;
   localparam logic [7:0] CMD_VND_LO = 8'hd0;
   localparam logic [7:0] CMD_VND_HI = 8'hef;
   localparam logic [7:0] OP_ON = 8'h80;
   localparam logic [7:0] OP_OFF = 8'h00;
   localparam logic [7:0] RD_FILL = 8'h00;
   localparam logic [7:0] CRC_POLY = 8'h07;
   localparam logic [7:0] BLK_MAX = 8'h30;
   localparam int SB_OV = 5;
   localparam int SB_OC = 4;
   localparam int SB_VUV = 3;
   localparam int SB_TMP = 2;
   localparam int SB_CML = 1;
   localparam int SW_OV = 7;
   localparam int SW_OC = 6;
   localparam int SW_VIN = 5;
   localparam int K_OV = 0;
   localparam int K_OC = 1;
   localparam int K_VUV = 2;
   localparam int K_VOV = 3;
   localparam int K_TMP = 4;
   localparam int K_CML = 5;
   localparam int unsigned MCLK_KHZ = 125000;
   localparam int unsigned T_LOCK_MS = 35;
   localparam int unsigned T_STR_MS = 25;
   localparam int unsigned LOCK_CYC_D = T_LOCK_MS * MCLK_KHZ;
   localparam int unsigned STR_CYC_D = T_STR_MS * MCLK_KHZ;
   localparam int unsigned RATE_STD_KHZ = 100;
   localparam int unsigned RATE_FAST_KHZ = 400;
   localparam int LIN_E_VOUT = -9;
   localparam logic ALERT_RST = 1'b1;
   localparam logic OP_RST = 1'b1;

   typedef enum logic [5:0]
   {
      L_IDLE = 6'b000001,
      L_RX = 6'b000010,
      L_RACK = 6'b000100,
      L_STR = 6'b001000,
      L_TX = 6'b010000,
      L_TACK = 6'b100000
   } pmb_ls_t;

   typedef struct packed {
      logic vin_uv;
      logic vin_ov;
      logic vout_uv;
      logic vout_ov;
      logic iout_oc;
      logic temp;
      logic intern;
   } pmb_flt_t;

   typedef struct packed {
      logic signed [4:0] e;
      logic signed [10:0] m;
   } pmb_lin_t;

   typedef struct packed {
      logic [7:0] code;
      logic vnd;
      logic blk;
      logic [7:0] cnt;
      logic vout_fix;
      logic [15:0] raw;
      pmb_lin_t lin;
   } pmb_cmd_t;

   function automatic logic [7:0] pmb_crc8(input logic [7:0] c, input logic [7:0] b);
      logic [7:0] x;
      x = c ^ b;
      for (int i = 0; i < 8; i++)
      begin
         x = x[7] ? ({x[6:0], 1'b0} ^ CRC_POLY) : {x[6:0], 1'b0};
      end
      return x;
   endfunction
endpackage

/* hdl/pmb_sync.sv */
`timescale 1ns/1ns
module pmb_sync
   import pmb_pkg::*;
#(
   parameter int W = 1
)(
   input wire logic clk_i,
   input wire logic arst_n_i,
   input wire logic [W-1:0] d_i,
   output logic [W-1:0] q_o
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } pmb_sy_t;
   pmb_sy_t sy_r;
   pmb_sy_t sy_nxt;

   always_comb
   begin
      sy_nxt.s1 = d_i;
      sy_nxt.s2 = sy_r.s1;
   end

   always_ff @(posedge clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
         sy_r <= '0;
      else
         sy_r <= sy_nxt;
   end

   assign q_o = sy_r.s2;
endmodule // pmb_sync

/* hdl/pmb_slave.sv */
`timescale 1ns/1ns
module pmb_slave
   import pmb_pkg::*;
#(
   parameter int unsigned LOCK_CYC = LOCK_CYC_D,
   parameter int unsigned STR_CYC = STR_CYC_D
)(
   input wire logic mclk_i,
   input wire logic lclk_i,
   input wire logic arst_n_i,
   input wire logic [2:0] slv_addr_i,
   input wire logic scl_i,
   output logic scl_o,
   output logic scl_oe_n_o,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_n_o,
   output logic alert_n_o,
   input wire pmb_flt_t flt_i,
   input wire logic ren_i,
   output logic op_on_o,
   output pmb_cmd_t cmd_o,
   output logic cmd_stb_o,
   output logic cmd_busy_o,
   input wire logic cmd_ack_i
);
   ////////////////////////////////////////////////////////////////////////////////
   typedef struct packed {
      logic scl;
      logic sda;
      pmb_flt_t flt;
      logic ren;
      logic lock;
      logic sexp;
      logic ack;
      logic [2:0] addr;
   } pmb_lsy_t;

   typedef struct packed {
      logic scl;
      logic sda;
      logic str;
      logic tgl;
   } pmb_msy_t;

   typedef struct packed {
      pmb_ls_t st;
      logic scl_p;
      logic sda_p;
      logic [3:0] bcnt;
      logic [7:0] sh;
      logic [6:0] idx;
      logic [7:0] nb;
      logic rd;
      logic bc;
      logic ack;
      logic [7:0] cmd;
      logic [7:0] d0;
      logic [7:0] d1;
      logic [7:0] d2;
      logic [7:0] crc;
      logic [7:0] crc_b;
      logic [1:0] tidx;
      logic scl_oen;
      logic sda_oen;
      logic pin_lvl;
      logic wr_tgl;
      pmb_cmd_t cout;
      pmb_flt_t flt_p;
      logic ren_p;
      logic [5:0] stk;
      logic alert_n;
      logic op_on;
   } pmb_lk_t;

   typedef struct packed {
      logic [31:0] lcnt;
      logic lock;
      logic [31:0] scnt;
      logic str_exp;
      logic tgl_p;
      logic ack_tgl;
      logic busy;
      logic stb;
      pmb_cmd_t cmd;
   } pmb_mc_t;

   pmb_lk_t lk_r;
   pmb_lk_t lk_nxt;
   pmb_mc_t mc_r;
   pmb_mc_t mc_nxt;
   pmb_lsy_t ls;
   pmb_msy_t ms;
   logic rise, fall, start, stop, busy, cml_set, al_set, al_clr, clr_all;
   logic [7:0] b, tb, stat_b, stat_h, need, nlen;
   logic is_pec, sup, vnd, blk, pec_in, len_ok, pec_ok;

   ////////////////////////////////////////////////////////////////////////////////
   // pins and cross-domain levels pass two flops before use
   pmb_sync #(.W($bits(pmb_lsy_t))) u_lsync (
      .clk_i(lclk_i),
      .arst_n_i(arst_n_i),
      .d_i({scl_i, sda_i, flt_i, ren_i, mc_r.lock, mc_r.str_exp, mc_r.ack_tgl, slv_addr_i}),
      .q_o(ls)
   );

   pmb_sync #(.W($bits(pmb_msy_t))) u_msync (
      .clk_i(mclk_i),
      .arst_n_i(arst_n_i),
      .d_i({scl_i, sda_i, ~lk_r.scl_oen, lk_r.wr_tgl}),
      .q_o(ms)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // link domain: bit engine, status and alert
   always_comb
   begin
      lk_nxt = lk_r;
      // oversampling on the link clock covers both bus rates alike
      rise = ls.scl & ~lk_r.scl_p;
      fall = ~ls.scl & lk_r.scl_p;
      start = ls.scl & lk_r.scl_p & lk_r.sda_p & ~ls.sda;
      stop = ls.scl & lk_r.scl_p & ~lk_r.sda_p & ls.sda;
      busy = lk_r.wr_tgl ^ ls.ack;
      b = {lk_r.sh[6:0], ls.sda};
      cml_set = 1'b0;
      al_clr = 1'b0;
      clr_all = 1'b0;
      stat_b = '0;
      stat_b[SB_OV] = lk_r.stk[K_OV];
      stat_b[SB_OC] = lk_r.stk[K_OC];
      stat_b[SB_VUV] = lk_r.stk[K_VUV];
      stat_b[SB_TMP] = lk_r.stk[K_TMP];
      stat_b[SB_CML] = lk_r.stk[K_CML];
      stat_h = '0;
      stat_h[SW_OV] = lk_r.stk[K_OV];
      stat_h[SW_OC] = lk_r.stk[K_OC];
      stat_h[SW_VIN] = lk_r.stk[K_VUV] | lk_r.stk[K_VOV];
      // only the status reads have data, the rest read back as zero
      tb = RD_FILL;
      is_pec = 1'b0;
      case (lk_r.cmd)
         CMD_STB:
         begin
            tb = (lk_r.tidx == 2'd0) ? stat_b : lk_r.crc;
            is_pec = (lk_r.tidx == 2'd1);
         end
         CMD_STW:
         begin
            tb = (lk_r.tidx == 2'd0) ? stat_b : (lk_r.tidx == 2'd1) ? stat_h : lk_r.crc;
            is_pec = (lk_r.tidx == 2'd2);
         end
         default:
         begin
            tb = RD_FILL;
         end
      endcase
      // write framing: expected data length, block count, trailing check byte
      vnd = (lk_r.cmd >= CMD_VND_LO) && (lk_r.cmd <= CMD_VND_HI);
      sup = vnd || (lk_r.cmd == CMD_OPER) || (lk_r.cmd == CMD_CLR)
         || (lk_r.cmd == CMD_WPROT) || (lk_r.cmd == CMD_VOUT);
      nlen = (lk_r.cmd == CMD_CLR) ? 8'd0
         : ((lk_r.cmd == CMD_OPER) || (lk_r.cmd == CMD_WPROT)) ? 8'd1 : 8'd2;
      blk = lk_r.nb > 8'd3;
      need = blk ? lk_r.d0 + 8'd1 : nlen;
      pec_in = (lk_r.nb == need + 8'd1);
      len_ok = ((lk_r.nb == need) || pec_in)
         && (!blk || ((lk_r.d0 != 8'd0) && (lk_r.d0 <= BLK_MAX)));
      pec_ok = !pec_in || (lk_r.crc_b == lk_r.d2);
      lk_nxt.scl_p = ls.scl;
      lk_nxt.sda_p = ls.sda;
      if (ls.lock)
      begin
         lk_nxt.st = L_IDLE;
         lk_nxt.scl_oen = 1'b1;
         lk_nxt.sda_oen = 1'b1;
      end
      else if (start)
      begin
         // a restart after the command byte keeps the running crc
         if ((lk_r.st == L_IDLE) || lk_r.rd || (lk_r.idx < 7'd2))
         begin
            lk_nxt.crc = '0;
            lk_nxt.nb = '0;
         end
         lk_nxt.st = L_RX;
         lk_nxt.bcnt = '0;
         lk_nxt.idx = '0;
         lk_nxt.tidx = '0;
         lk_nxt.sda_oen = 1'b1;
         lk_nxt.scl_oen = 1'b1;
      end
      else if (stop)
      begin
         lk_nxt.st = L_IDLE;
         lk_nxt.sda_oen = 1'b1;
         lk_nxt.scl_oen = 1'b1;
         if ((lk_r.st != L_IDLE) && !lk_r.rd && (lk_r.idx >= 7'd2))
         begin
            if (!sup || !len_ok)
               cml_set = 1'b1;
            else if (!pec_ok)
               cml_set = 1'b1;
            else if (lk_r.cmd == CMD_CLR)
               clr_all = 1'b1;
            else if (busy)
               cml_set = 1'b1;
            else
            begin
               if (lk_r.cmd == CMD_OPER)
               begin
                  if ((lk_r.d0 == OP_ON) && !lk_r.op_on)
                     al_clr = 1'b1;
                  if (lk_r.d0 == OP_ON)
                     lk_nxt.op_on = 1'b1;
                  else if (lk_r.d0 == OP_OFF)
                     lk_nxt.op_on = 1'b0;
               end
               lk_nxt.cout.code = lk_r.cmd;
               lk_nxt.cout.vnd = vnd;
               lk_nxt.cout.blk = blk;
               lk_nxt.cout.cnt = lk_r.nb;
               // output voltage words are a plain mantissa at 2^-9
               lk_nxt.cout.vout_fix = (lk_r.cmd == CMD_VOUT);
               lk_nxt.cout.raw = blk ? {lk_r.d2, lk_r.d1} : {lk_r.d1, lk_r.d0};
               lk_nxt.cout.lin = pmb_lin_t'({lk_r.d1, lk_r.d0});
               lk_nxt.wr_tgl = ~lk_r.wr_tgl;
            end
         end
      end
      else
      begin
         case (lk_r.st)
            L_IDLE:
            begin
               lk_nxt.sda_oen = 1'b1;
               lk_nxt.scl_oen = 1'b1;
            end
            L_RX:
            begin
               if (rise && (lk_r.bcnt < 4'd8))
               begin
                  lk_nxt.sh = b;
                  lk_nxt.bcnt = lk_r.bcnt + 4'd1;
                  if (lk_r.bcnt == 4'd7)
                  begin
                     lk_nxt.crc_b = lk_r.crc;
                     lk_nxt.crc = pmb_crc8(lk_r.crc, b);
                     lk_nxt.ack = 1'b1;
                     if (lk_r.idx == 7'd0)
                     begin
                        lk_nxt.rd = b[0];
                        lk_nxt.bc = (b[7:1] == ADDR_BCAST);
                        lk_nxt.ack = (b[7:1] == {ADDR_HI, ls.addr})
                           || ((b[7:1] == ADDR_BCAST) && !b[0]);
                        cml_set = (b[7:1] == ADDR_BCAST) && b[0];
                     end
                     else if (lk_r.idx == 7'd1)
                        lk_nxt.cmd = b;
                     else
                     begin
                        lk_nxt.nb = (lk_r.nb == 8'hff) ? lk_r.nb : lk_r.nb + 8'd1;
                        if (lk_r.nb == 8'd0)
                           lk_nxt.d0 = b;
                        if (lk_r.nb == 8'd1)
                           lk_nxt.d1 = b;
                        lk_nxt.d2 = b;
                     end
                  end
               end
               else if (fall && (lk_r.bcnt == 4'd8))
               begin
                  lk_nxt.st = lk_r.ack ? L_RACK : L_IDLE;
                  lk_nxt.sda_oen = ~lk_r.ack;
               end
            end
            L_RACK:
            begin
               if (fall)
               begin
                  lk_nxt.sda_oen = 1'b1;
                  lk_nxt.bcnt = '0;
                  lk_nxt.idx = (lk_r.idx == 7'h7f) ? lk_r.idx : lk_r.idx + 7'd1;
                  if (lk_r.rd && (lk_r.idx == 7'd0))
                  begin
                     if ((lk_r.cmd == CMD_STB) || (lk_r.cmd == CMD_STW))
                        al_clr = 1'b1;
                     else if (!lk_r.bc)
                        cml_set = 1'b1;
                  end
                  // hold the clock only here, after the ninth bit
                  if (busy && !ls.sexp)
                  begin
                     lk_nxt.st = L_STR;
                     lk_nxt.scl_oen = 1'b0;
                  end
                  else
                     lk_nxt.st = lk_r.rd ? L_TX : L_RX;
                  if (lk_r.rd && !(busy && !ls.sexp))
                  begin
                     lk_nxt.sh = tb;
                     lk_nxt.sda_oen = tb[7];
                     lk_nxt.tidx = lk_r.tidx + 2'd1;
                     if (!is_pec)
                        lk_nxt.crc = pmb_crc8(lk_r.crc, tb);
                  end
               end
            end
            L_STR:
            begin
               // the master sees the released clock and resumes
               if (!busy || ls.sexp)
               begin
                  lk_nxt.scl_oen = 1'b1;
                  lk_nxt.st = lk_r.rd ? L_TX : L_RX;
                  if (lk_r.rd)
                  begin
                     lk_nxt.sh = tb;
                     lk_nxt.sda_oen = tb[7];
                     lk_nxt.tidx = lk_r.tidx + 2'd1;
                     if (!is_pec)
                        lk_nxt.crc = pmb_crc8(lk_r.crc, tb);
                  end
               end
            end
            L_TX:
            begin
               if (fall)
               begin
                  lk_nxt.bcnt = lk_r.bcnt + 4'd1;
                  lk_nxt.sh = {lk_r.sh[6:0], 1'b0};
                  lk_nxt.sda_oen = lk_r.sh[6];
                  if (lk_r.bcnt == 4'd7)
                  begin
                     lk_nxt.sda_oen = 1'b1;
                     lk_nxt.st = L_TACK;
                     lk_nxt.ack = 1'b0;
                  end
               end
            end
            L_TACK:
            begin
               if (rise)
                  lk_nxt.ack = ~ls.sda;
               else if (fall)
               begin
                  // a missing acknowledge ends our part of the read
                  lk_nxt.bcnt = '0;
                  lk_nxt.st = lk_r.ack ? L_TX : L_IDLE;
                  lk_nxt.sda_oen = lk_r.ack ? tb[7] : 1'b1;
                  lk_nxt.sh = tb;
                  if (lk_r.ack)
                  begin
                     lk_nxt.tidx = (lk_r.tidx == 2'd3) ? lk_r.tidx : lk_r.tidx + 2'd1;
                     if (!is_pec)
                        lk_nxt.crc = pmb_crc8(lk_r.crc, tb);
                  end
               end
            end
            default:
            begin
               lk_nxt.st = L_IDLE;
               lk_nxt.sda_oen = 1'b1;
               lk_nxt.scl_oen = 1'b1;
            end
         endcase
      end
      // status: sticky, cleared by 03, present faults set again at once
      lk_nxt.flt_p = ls.flt;
      lk_nxt.ren_p = ls.ren;
      if (ls.ren && !lk_r.ren_p)
         al_clr = 1'b1;
      lk_nxt.stk = (clr_all ? 6'h00 : lk_r.stk)
         | {cml_set, ls.flt.temp, ls.flt.vin_ov, ls.flt.vin_uv,
            ls.flt.iout_oc, ls.flt.vout_ov};
      al_set = (ls.flt != lk_r.flt_p) || cml_set
         || (clr_all && (ls.flt != '0));
      if (clr_all)
         al_clr = 1'b1;
      // set beats clear so no event slips through a clear
      if (al_set)
         lk_nxt.alert_n = 1'b0;
      else if (al_clr)
         lk_nxt.alert_n = 1'b1;
      lk_nxt.pin_lvl = 1'b0;
   end

   always_ff @(posedge lclk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         lk_r <= '0;
         lk_r.st <= L_IDLE;
         lk_r.scl_oen <= 1'b1;
         lk_r.sda_oen <= 1'b1;
         lk_r.alert_n <= ALERT_RST;
         lk_r.op_on <= OP_RST;
      end
      else
         lk_r <= lk_nxt;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // system domain: lock-up and stretch timers, command hand-off
   always_comb
   begin
      mc_nxt = mc_r;
      mc_nxt.stb = 1'b0;
      if (!ms.scl || !ms.sda)
         mc_nxt.lcnt = (mc_r.lcnt < LOCK_CYC) ? mc_r.lcnt + 32'd1 : mc_r.lcnt;
      else
         mc_nxt.lcnt = '0;
      mc_nxt.lock = (mc_nxt.lcnt >= LOCK_CYC);
      if (ms.str)
         mc_nxt.scnt = (mc_r.scnt < STR_CYC) ? mc_r.scnt + 32'd1 : mc_r.scnt;
      else
         mc_nxt.scnt = '0;
      // the cap trips a little late by the crossing, well inside the limit
      mc_nxt.str_exp = (mc_nxt.scnt >= STR_CYC);
      // the command word is stable in the link domain until acknowledged
      if (ms.tgl != mc_r.tgl_p)
      begin
         mc_nxt.tgl_p = ms.tgl;
         mc_nxt.cmd = lk_r.cout;
         mc_nxt.stb = 1'b1;
         mc_nxt.busy = 1'b1;
      end
      else if (mc_r.busy && cmd_ack_i)
      begin
         mc_nxt.busy = 1'b0;
         mc_nxt.ack_tgl = ~mc_r.ack_tgl;
      end
   end

   always_ff @(posedge mclk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
         mc_r <= '0;
      else
         mc_r <= mc_nxt;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // the clock pin is only ever released or held, never pulsed
   assign scl_o = lk_r.pin_lvl;
   assign scl_oe_n_o = lk_r.scl_oen;
   assign sda_o = lk_r.pin_lvl;
   assign sda_oe_n_o = lk_r.sda_oen;
   assign alert_n_o = lk_r.alert_n;
   assign op_on_o = lk_r.op_on;
   assign cmd_o = mc_r.cmd;
   assign cmd_stb_o = mc_r.stb;
   assign cmd_busy_o = mc_r.busy;
endmodule // pmb_slave

/* test/pmb_slave_sva.sv */
`timescale 1ns/1ns
module pmb_slave_sva
   import pmb_pkg::*;
#(
   parameter int unsigned LOCK_CYC = 20000,
   parameter int unsigned STR_CYC = 1000
)(
   input wire logic mclk_i,
   input wire logic lclk_i,
   input wire logic arst_n_i,
   input wire logic scl_i,
   input wire logic scl_o,
   input wire logic scl_oe_n_o,
   input wire logic sda_i,
   input wire logic sda_o,
   input wire logic sda_oe_n_o,
   input wire logic alert_n_o,
   input wire pmb_flt_t flt_i,
   input wire pmb_cmd_t cmd_o,
   input wire logic cmd_stb_o,
   input wire logic cmd_busy_o,
   input wire logic cmd_ack_i
);
   // 32 bits never wrap within a run
   logic [31:0] s_cnt_r;
   logic [31:0] l_cnt_r;
   always_ff @(posedge mclk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         s_cnt_r <= '0;
         l_cnt_r <= '0;
      end
      else
      begin
         s_cnt_r <= scl_oe_n_o ? '0 : s_cnt_r + 1;
         l_cnt_r <= (scl_i && sda_i) ? '0 : l_cnt_r + 1;
      end
   end
   ////////////////////////////////////////
   a_pins_zero: assert property (@(posedge lclk_i) disable iff (!arst_n_i)
      !scl_o && !sda_o) else $error("pin out not zero");
   a_hold_low: assert property (@(posedge lclk_i) disable iff (!arst_n_i)
      $fell(scl_oe_n_o) |-> !scl_i) else $error("clock pulled while high");
   a_stretch_max: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
      s_cnt_r <= STR_CYC + 64) else $error("stretch too long");
   a_lock_free: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
      l_cnt_r > LOCK_CYC + 64 |-> scl_oe_n_o && sda_oe_n_o) else $error("bus kept");
   a_stb_busy: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
      cmd_stb_o |-> cmd_busy_o ##1 !cmd_stb_o) else $error("bad strobe");
   a_ack_busy: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
      cmd_busy_o && cmd_ack_i |=> !cmd_busy_o) else $error("busy stuck");
   a_vnd_flag: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
      cmd_stb_o |=> cmd_o.vnd == (cmd_o.code inside {[CMD_VND_LO:CMD_VND_HI]}))
      else $error("vendor flag wrong");
   a_lin_split: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
      cmd_stb_o |=> cmd_o.lin == cmd_o.raw) else $error("linear split wrong");
   a_alert_set: assert property (@(posedge lclk_i) disable iff (!arst_n_i)
      $changed(flt_i) |-> ##[1:6] !alert_n_o) else $error("alert not set");
endmodule // pmb_slave_sva

/* test/pmb_host.sv */
`timescale 1ns/1ns
module pmb_host #(
   // half bit in system clocks: faster than either bus rate to keep runs short
   parameter int H = 50
)(
   input wire logic mclk_i,
   input wire logic scl_i,
   input wire logic sda_i,
   output logic scl_d_o,
   output logic sda_d_o
);
   initial
   begin
      scl_d_o = 1'b1;
      sda_d_o = 1'b1;
   end
   task automatic hw();
      repeat (H) @(posedge mclk_i);
      #1;
   endtask
   // a high drive is a release: the pull-up decides the wire
   task automatic bit_x(input logic b, output logic r);
      sda_d_o = b;
      hw();
      scl_d_o = 1'b1;
      wait (scl_i);
      hw();
      r = sda_i;
      scl_d_o = 1'b0;
   endtask
   task automatic start();
      sda_d_o = 1'b1;
      hw();
      scl_d_o = 1'b1;
      wait (scl_i);
      hw();
      sda_d_o = 1'b0;
      hw();
      scl_d_o = 1'b0;
   endtask
   task automatic stop();
      sda_d_o = 1'b0;
      hw();
      scl_d_o = 1'b1;
      wait (scl_i);
      hw();
      sda_d_o = 1'b1;
      hw();
   endtask
   task automatic xfer(input logic [7:0] d, input logic a, output logic [7:0] q, output logic k);
      for (int i = 7; i >= 0; i--)
         bit_x(d[i], q[i]);
      bit_x(a, k);
   endtask
endmodule // pmb_host

/* test/tb_top.sv */
`timescale 1ns/1ns
module tb_top;
   import pmb_pkg::*;
   localparam int LC = 6000;
   logic mclk_i = 0;
   logic lclk_i = 0;
   logic arst_n_i = 0;
   logic [2:0] slv_addr_i = 0;
   pmb_flt_t flt_i = '0;
   logic ren_i = 1;
   logic cmd_ack_i = 0;
   logic ack_en = 1;
   wire scl_d, sda_d, scl_o, scl_oe_n_o, sda_o, sda_oe_n_o, alert_n_o, op_on_o;
   wire cmd_stb_o, cmd_busy_o;
   wire pmb_cmd_t cmd_o;
   wire scl_i = scl_d & (scl_oe_n_o | scl_o);
   wire sda_i = sda_d & (sda_oe_n_o | sda_o);
   int fails = 0;
   int cmp_count = 0;
   int n_stb = 0;
   logic [15:0] rnd = 16'hbcb5;
   logic [7:0] aw, cc, sb;
   logic [7:0] q[$];
   always #4 mclk_i = ~mclk_i;
   always #15 lclk_i = ~lclk_i;
   always @(posedge mclk_i) if (cmd_stb_o === 1'b1) n_stb++;
   always @(posedge mclk_i) cmd_ack_i <= #1 cmd_busy_o & ack_en;
   pmb_slave #(.LOCK_CYC(LC), .STR_CYC(1000)) dut_u (.mclk_i, .lclk_i, .arst_n_i, .slv_addr_i,
      .scl_i, .scl_o, .scl_oe_n_o, .sda_i, .sda_o, .sda_oe_n_o, .alert_n_o, .flt_i, .ren_i,
      .op_on_o, .cmd_o, .cmd_stb_o, .cmd_busy_o, .cmd_ack_i);
   pmb_host host_u (.mclk_i, .scl_i, .sda_i, .scl_d_o(scl_d), .sda_d_o(sda_d));
   ////////////////////////////////////////
   function automatic logic [15:0] lf(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   function automatic logic [7:0] crc(input logic [7:0] b[$]);
      logic [7:0] c;
      c = '0;
      foreach (b[i])
      begin
         c ^= b[i];
         repeat (8) c = c[7] ? (c << 1) ^ CRC_POLY : c << 1;
      end
      return c;
   endfunction
   task automatic chk(input logic [15:0] s, input logic [15:0] e);
      cmp_count++;
      if (s !== e)
      begin
         fails++;
         $display("Error %0t: got %h want %h", $time, s, e);
      end
   endtask
   task automatic end_of_test();
      if (fails == 0 && cmp_count > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge mclk_i);
      #1;
   endtask
   // p: 0 no check byte, 1 good one, 2 corrupted one
   task automatic wr(input logic [7:0] b[$], input int p, input logic ea);
      logic [7:0] d;
      logic k;
      if (p > 0)
         b.push_back(crc(b) ^ (p == 2 ? 8'h01 : 8'h00));
      host_u.start();
      foreach (b[i])
      begin
         host_u.xfer(b[i], 1'b1, d, k);
         chk(k, ea);
      end
      host_u.stop();
      cyc(32);
   endtask
   task automatic rd(input logic [7:0] c, input int n, input logic [15:0] e, input logic pc);
      logic [7:0] d;
      logic [15:0] v;
      logic k;
      v = '0;
      q = {aw, c, aw | 8'h01};
      host_u.start();
      host_u.xfer(aw, 1'b1, d, k);
      host_u.xfer(c, 1'b1, d, k);
      host_u.start();
      host_u.xfer(q[2], 1'b1, d, k);
      chk(k, 0);
      for (int i = 0; i < n; i++)
      begin
         host_u.xfer(8'hff, 1'b0, d, k);
         v[8*i +: 8] = d;
         q.push_back(d);
      end
      host_u.xfer(8'hff, 1'b1, d, k);
      host_u.stop();
      cyc(32);
      chk(v, e);
      if (pc)
         chk(d, crc(q));
   endtask
   ////////////////////////////////////////
   initial
   begin
      #3000000;
      fails++;
      end_of_test();
   end
   initial
   begin
      rnd = lf(rnd);
      slv_addr_i = rnd[2:0];
      aw = {ADDR_HI, slv_addr_i, 1'b0};
      cyc(3);
      arst_n_i = 1'b1;
      cyc(10);
      chk({alert_n_o, op_on_o, scl_oe_n_o, sda_oe_n_o}, 16'hf);
      rnd = lf(rnd);
      wr({aw, CMD_VOUT, rnd[7:0], rnd[15:8]}, 1, 0);
      chk(cmd_o.raw, rnd);
      wr({aw, CMD_VOUT, rnd[15:8], rnd[7:0]}, 2, 0);
      chk({n_stb[7:0], alert_n_o}, 16'h2);
      sb = 8'h01 << SB_CML;
      rd(CMD_STW, 2, {8'h00, sb}, 1);
      chk(alert_n_o, 1);
      wr({aw, CMD_CLR}, 0, 0);
      cyc(1);
      flt_i.temp = 1'b1;
      cyc(16);
      chk(alert_n_o, 0);
      rd(CMD_STB, 1, 16'h1 << SB_TMP, 1);
      wr({aw, CMD_CLR}, 1, 0);
      chk(alert_n_o, 0);
      flt_i.temp = 1'b0;
      cyc(8);
      wr({8'h00, CMD_CLR}, 0, 0);
      chk(alert_n_o, 1);
      rd(8'h8b, 2, 16'h0, 0);
      chk(alert_n_o, 0);
      rd(CMD_STB, 1, 16'h1 << SB_CML, 1);
      flt_i.iout_oc = 1'b1;
      wr({8'h00, CMD_OPER, OP_OFF}, 1, 0);
      chk({op_on_o, alert_n_o}, 16'h0);
      wr({aw, CMD_OPER, OP_ON}, 1, 0);
      chk({op_on_o, alert_n_o}, 16'h3);
      flt_i.iout_oc = 1'b0;
      cyc(16);
      ren_i = 1'b0;
      cyc(16);
      ren_i = 1'b1;
      cyc(16);
      chk(alert_n_o, 1);
      wr({{4'ha, slv_addr_i, 1'b0}}, 0, 1);
      wr({8'h01}, 0, 1);
      chk(alert_n_o, 0);
      rnd = lf(rnd);
      cc = CMD_VND_LO | {3'h0, rnd[4:0]};
      wr({aw, cc, rnd[7:0], rnd[15:8]}, 1, 0);
      chk({cmd_o.vnd, cmd_o.code}, {8'h01, cc});
      // user holds off its acknowledge: acks get stretched, a finished write is dropped
      ack_en = 1'b0;
      wr({aw, CMD_WPROT, 8'h00}, 1, 0);
      wr({aw, CMD_CLR}, 1, 0);
      chk(alert_n_o, 1);
      wr({aw, CMD_OPER, OP_ON}, 0, 0);
      chk({n_stb[7:0], alert_n_o}, 16'ha);
      ack_en = 1'b1;
      // lock-up while the device still holds its acknowledge low
      host_u.start();
      for (int i = 7; i >= 0; i--)
         host_u.bit_x(aw[i], sb[i]);
      host_u.sda_d_o = 1'b1;
      host_u.hw();
      chk(sda_oe_n_o, 0);
      host_u.scl_d_o = 1'b1;
      cyc(LC + 500);
      chk({scl_oe_n_o, sda_oe_n_o}, 16'h3);
      end_of_test();
   end
endmodule // tb_top
bind pmb_slave pmb_slave_sva #(.LOCK_CYC(LOCK_CYC), .STR_CYC(STR_CYC)) sva_u (.mclk_i, .lclk_i,
   .arst_n_i, .scl_i, .scl_o, .scl_oe_n_o, .sda_i, .sda_o, .sda_oe_n_o, .alert_n_o, .flt_i,
   .cmd_o, .cmd_stb_o, .cmd_busy_o, .cmd_ack_i);
